// File: hw/nvsec_top.sv
// Option and protection load at reset with backdoor key security control.
`timescale 1ns/1ps
`default_nettype none
module nvsec_top
  import nvsec_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic exec_secure,
  input wire logic bdm_access,
  output logic nv_rd_req,
  output logic [15:0] nv_rd_addr,
  input wire logic [7:0] nv_rd_data,
  input wire logic nv_rd_valid,
  input wire logic [63:0] stored_key,
  input wire logic flash_cmd_done,
  input wire logic [7:0] flash_cmd_code,
  input wire logic flash_blank,
  output logic load_done,
  output logic secure,
  output logic key_enabled
);

  import nvsec_pkg::*;

  nvsec_state_type state_ff;
  logic [7:0] protection_working_reg_ff;
  logic [7:0] option_working_reg_ff;
  logic key_access_ff;
  logic unlocked_ff;
  logic erased_ff;
  logic [7:0] rdata_ff;
  logic key_failed_ff;
  logic cmp_start;
  logic cmp_byte_valid;
  logic cmp_done;
  logic cmp_match;
  logic backdoor_key_enable;
  logic secure_code;
  logic key_write_ok;

  // A write strobe aimed at one register address.
  function automatic logic wr_hit(input logic [15:0] addr, input logic wr,
                                  input logic [15:0] target);
    return wr && (addr == target);
  endfunction : wr_hit

  // ****************************************************************************
  // Working-register load after reset.
  // ****************************************************************************

  // Protection then option bytes are fetched from the stored area on every reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= NVSEC_LOAD_PROT;
    end else begin
      unique case (state_ff)
        NVSEC_LOAD_PROT: begin
          // The first valid byte on the load link is the protection byte.
          if (nv_rd_valid) begin
            state_ff <= NVSEC_LOAD_OPT;
          end
        end
        NVSEC_LOAD_OPT: begin
          // The second valid byte on the load link is the option byte.
          if (nv_rd_valid) begin
            state_ff <= NVSEC_LOAD_WAIT;
          end
        end
        NVSEC_LOAD_WAIT: begin
          state_ff <= NVSEC_RUN;
        end
        NVSEC_RUN: begin
          state_ff <= NVSEC_RUN;
        end
      endcase
    end
  end

  assign nv_rd_req = (state_ff == NVSEC_LOAD_PROT) || (state_ff == NVSEC_LOAD_OPT);
  assign nv_rd_addr = (state_ff == NVSEC_LOAD_OPT) ? NVSEC_STORED_OPTIONS_ADDR :
                      NVSEC_STORED_PROTECTION_ADDR;
  assign load_done = (state_ff == NVSEC_RUN);

  // Working copies; reset makes them secure until the stored bytes arrive.
  always_ff @(posedge clk) begin
    if (rst) begin
      protection_working_reg_ff <= 8'h00;
      option_working_reg_ff <= 8'h00;
    end else if (nv_rd_valid && state_ff == NVSEC_LOAD_PROT) begin
      protection_working_reg_ff <= nv_rd_data & NVSEC_PROTECT_VALID_MASK;
    end else if (nv_rd_valid && state_ff == NVSEC_LOAD_OPT) begin
      option_working_reg_ff <= nv_rd_data & NVSEC_OPTION_VALID_MASK;
    end
  end

  // ****************************************************************************
  // Security state.
  // ****************************************************************************

  assign backdoor_key_enable = option_working_reg_ff[NVSEC_KEY_ENABLE_BIT];
  assign secure_code = (option_working_reg_ff[1:0] != NVSEC_UNSECURED_CODE);
  assign key_enabled = backdoor_key_enable;

  // Key bytes only count when secure code wrote them, never from debug.
  assign key_write_ok = wr_hit(reg_addr, reg_wr, NVSEC_KEY_ENTRY_ADDR) && key_access_ff
                        && exec_secure && !bdm_access && backdoor_key_enable;
  assign cmp_byte_valid = key_write_ok;
  assign cmp_start = wr_hit(reg_addr, reg_wr, NVSEC_FLASH_CONFIG_ADDR)
                     && reg_wdata[NVSEC_KEY_ACCESS_BIT] && exec_secure && !bdm_access;

  // Key access mode bit in the flash config register, secure code only.
  always_ff @(posedge clk) begin
    if (rst) begin
      key_access_ff <= 1'b0;
    end else if (wr_hit(reg_addr, reg_wr, NVSEC_FLASH_CONFIG_ADDR)) begin
      if (exec_secure && !bdm_access) begin
        key_access_ff <= reg_wdata[NVSEC_KEY_ACCESS_BIT] & backdoor_key_enable;
      end
    end else if (cmp_done) begin
      key_access_ff <= 1'b0;
    end
  end

  nvsec_key_cmp u_cmp (
    .clk(clk),
    .rst(rst),
    .start(cmp_start),
    .byte_valid(cmp_byte_valid),
    .byte_data(reg_wdata),
    .stored_key(stored_key),
    .done(cmp_done),
    .match(cmp_match)
  );

  // A full matching key unlocks until the next reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      unlocked_ff <= 1'b0;
      key_failed_ff <= 1'b0;
    end else if (cmp_done) begin
      if (cmp_match && backdoor_key_enable) begin
        unlocked_ff <= 1'b1;
      end
      key_failed_ff <= !cmp_match;
    end
  end

  // Mass erase followed by a clean blank check releases security.
  always_ff @(posedge clk) begin
    if (rst) begin
      erased_ff <= 1'b0;
    end else if (flash_cmd_done && flash_cmd_code == NVSEC_CMD_MASS_ERASE) begin
      erased_ff <= 1'b1;
    end else if (flash_cmd_done && flash_cmd_code != NVSEC_CMD_BLANK_CHECK) begin
      erased_ff <= 1'b0;
    end
  end

  logic blank_ok_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      blank_ok_ff <= 1'b0;
    end else if (flash_cmd_done && flash_cmd_code == NVSEC_CMD_BLANK_CHECK
                 && erased_ff && flash_blank) begin
      blank_ok_ff <= 1'b1;
    end
  end

  // Until loaded, memory is treated as secure.
  assign secure = !load_done || (secure_code && !unlocked_ff && !blank_ok_ff);

  // ****************************************************************************
  // Register read port.
  // ****************************************************************************

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        NVSEC_OPTION_WORKING_ADDR: rdata_ff <= option_working_reg_ff;
        NVSEC_FLASH_CONFIG_ADDR: rdata_ff <= {2'h0, key_access_ff, 5'h00};
        NVSEC_PROTECTION_WORKING_ADDR: rdata_ff <= protection_working_reg_ff;
        NVSEC_STATUS_ADDR: rdata_ff <= {4'h0, key_failed_ff, blank_ok_ff, unlocked_ff, secure};
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;

  // ****************************************************************************
  // Checks.
  // ****************************************************************************

  load_prot_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == NVSEC_LOAD_PROT && nv_rd_valid |=>
    protection_working_reg_ff == ($past(nv_rd_data) & NVSEC_PROTECT_VALID_MASK))
    else $error("protection byte not loaded");
  load_opt_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == NVSEC_LOAD_OPT && nv_rd_valid |=>
    option_working_reg_ff == ($past(nv_rd_data) & NVSEC_OPTION_VALID_MASK))
    else $error("option byte not loaded");
  key_gate_a: assert property (@(posedge clk) disable iff (rst)
    $rose(unlocked_ff) |-> backdoor_key_enable && $past(cmp_done))
    else $error("unlock without enabled key");
  key_origin_a: assert property (@(posedge clk) disable iff (rst)
    cmp_byte_valid |-> exec_secure)
    else $error("key byte from non-secure code");
  no_debug_a: assert property (@(posedge clk) disable iff (rst)
    cmp_byte_valid |-> !bdm_access)
    else $error("key byte from debug");
  key_off_a: assert property (@(posedge clk) disable iff (rst)
    !backdoor_key_enable |-> !key_access_ff ##1 !$rose(unlocked_ff))
    else $error("key active while disabled");
  blank_rel_a: assert property (@(posedge clk) disable iff (rst)
    $rose(blank_ok_ff) |-> $past(erased_ff))
    else $error("release without erase");
  unsec_code_a: assert property (@(posedge clk) disable iff (rst)
    load_done && option_working_reg_ff[1:0] == NVSEC_UNSECURED_CODE |-> !secure)
    else $error("unsecured code still secure");
  hold_sec_a: assert property (@(posedge clk) disable iff (rst)
    secure_code && !unlocked_ff && !blank_ok_ff |-> secure)
    else $error("secure memory released");

  // The protection fetch addresses the stored protection byte.
  fetch_prot_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == NVSEC_LOAD_PROT |-> nv_rd_req && nv_rd_addr == NVSEC_STORED_PROTECTION_ADDR)
    else $error("protection fetch address wrong");

  // The option fetch addresses the stored option byte.
  fetch_opt_a: assert property (@(posedge clk) disable iff (rst)
    state_ff == NVSEC_LOAD_OPT |-> nv_rd_req && nv_rd_addr == NVSEC_STORED_OPTIONS_ADDR)
    else $error("option fetch address wrong");

  // Fetching stops once both bytes are in.
  fetch_stop_a: assert property (@(posedge clk) disable iff (rst)
    load_done |-> !nv_rd_req)
    else $error("fetch after load done");

  // Loaded working copies stand unchanged until the next reset.
  load_hold_a: assert property (@(posedge clk) disable iff (rst)
    load_done |=> load_done && $stable(protection_working_reg_ff) && $stable(option_working_reg_ff))
    else $error("working copy changed after load");

  // Memory counts as secure while the load is still running.
  load_secure_a: assert property (@(posedge clk) disable iff (rst)
    !load_done |-> secure)
    else $error("released before load done");

  // Key access opens only for secure code that is not debug.
  access_origin_a: assert property (@(posedge clk) disable iff (rst)
    $rose(key_access_ff) |-> $past(exec_secure) && !$past(bdm_access))
    else $error("key access opened from wrong origin");

  // Key access never stands while the key is disabled.
  access_enable_a: assert property (@(posedge clk) disable iff (rst)
    key_access_ff |-> backdoor_key_enable)
    else $error("key access with key disabled");

  // No key byte counts while the key is disabled.
  key_off_byte_a: assert property (@(posedge clk) disable iff (rst)
    !backdoor_key_enable |-> !cmp_byte_valid)
    else $error("key byte counted while disabled");

  // A finished compare closes key access unless the flash config register is written in the same cycle.
  key_clear_a: assert property (@(posedge clk) disable iff (rst)
    cmp_done && !wr_hit(reg_addr, reg_wr, NVSEC_FLASH_CONFIG_ADDR) |=> !key_access_ff)
    else $error("key access left open");

  // An unlock lasts until reset.
  unlock_hold_a: assert property (@(posedge clk) disable iff (rst)
    unlocked_ff |=> unlocked_ff)
    else $error("unlock lost before reset");

  // An unlock needs a matching compare.
  unlock_match_a: assert property (@(posedge clk) disable iff (rst)
    $rose(unlocked_ff) |-> $past(cmp_match))
    else $error("unlock without match");

  // A failed flag needs a mismatching compare.
  fail_flag_a: assert property (@(posedge clk) disable iff (rst)
    $rose(key_failed_ff) |-> !$past(cmp_match))
    else $error("fail flag without mismatch");

  // The erase record starts only from a mass erase.
  erase_mark_a: assert property (@(posedge clk) disable iff (rst)
    $rose(erased_ff) |-> $past(flash_cmd_done) && $past(flash_cmd_code) == NVSEC_CMD_MASS_ERASE)
    else $error("erase record without mass erase");

  // Release by erase needs a blank check that found the flash blank.
  blank_check_a: assert property (@(posedge clk) disable iff (rst)
    $rose(blank_ok_ff) |-> $past(flash_cmd_code) == NVSEC_CMD_BLANK_CHECK && $past(flash_blank))
    else $error("release without blank check");

  // Release by erase lasts until reset.
  blank_hold_a: assert property (@(posedge clk) disable iff (rst)
    blank_ok_ff |=> blank_ok_ff)
    else $error("erase release lost");

  // Without unlock or erase, the loaded code alone decides security.
  secure_code_a: assert property (@(posedge clk) disable iff (rst)
    load_done && !unlocked_ff && !blank_ok_ff |->
    secure == (option_working_reg_ff[1:0] != NVSEC_UNSECURED_CODE))
    else $error("security not set by code");

  // Memory is open only for a known reason.
  release_a: assert property (@(posedge clk) disable iff (rst)
    !secure |-> load_done && (unlocked_ff || blank_ok_ff || !secure_code))
    else $error("released without cause");

  // Read data stand only in the cycle after a read strobe.
  rd_idle_a: assert property (@(posedge clk) disable iff (rst)
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");

  // Reading the option working register returns the loaded copy.
  rd_option_a: assert property (@(posedge clk) disable iff (rst)
    $past(reg_rd) && $past(reg_addr) == NVSEC_OPTION_WORKING_ADDR |->
    reg_rdata == $past(option_working_reg_ff))
    else $error("option read wrong");

  // Reading the protection working register returns the loaded copy.
  rd_prot_a: assert property (@(posedge clk) disable iff (rst)
    $past(reg_rd) && $past(reg_addr) == NVSEC_PROTECTION_WORKING_ADDR |->
    reg_rdata == $past(protection_working_reg_ff))
    else $error("protection read wrong");

  // ****************************************************************************
  // Scenario covers.
  // ****************************************************************************

  // Load, unlock, erase release, failed key and erase release with the key off.
  load_seen_c: cover property (@(posedge clk) disable iff (rst) $rose(load_done));
  unlock_seen_c: cover property (@(posedge clk) disable iff (rst) $rose(unlocked_ff));
  blank_seen_c: cover property (@(posedge clk) disable iff (rst) $rose(blank_ok_ff));
  fail_seen_c: cover property (@(posedge clk) disable iff (rst) $rose(key_failed_ff));
  erase_off_c: cover property (@(posedge clk) disable iff (rst)
    $rose(blank_ok_ff) && !backdoor_key_enable);

endmodule : nvsec_top
`default_nettype wire

// File: pkg/nvsec_pkg.sv
// Constants and types shared by the option-load and backdoor-key security block.
// ****************************************************************************
// ****************************************************************************
package nvsec_pkg;

  // ****************************************************************************
  // Register map.
  // ****************************************************************************
  localparam logic [15:0] NVSEC_OPTION_WORKING_ADDR = 16'h1821;
  localparam logic [15:0] NVSEC_FLASH_CONFIG_ADDR = 16'h1823;
  localparam logic [15:0] NVSEC_PROTECTION_WORKING_ADDR = 16'h1824;
  localparam logic [15:0] NVSEC_KEY_ENTRY_ADDR = 16'h1830;
  localparam logic [15:0] NVSEC_STATUS_ADDR = 16'h1831;
  localparam logic [15:0] NVSEC_BACKDOOR_KEY_ADDR = 16'hFFB0;
  localparam logic [15:0] NVSEC_STORED_PROTECTION_ADDR = 16'hFFBD;
  localparam logic [15:0] NVSEC_STORED_OPTIONS_ADDR = 16'hFFBF;

  // ****************************************************************************
  // Field positions and values.
  // ****************************************************************************
  localparam int NVSEC_KEY_ENABLE_BIT = 7;
  localparam int NVSEC_KEY_ACCESS_BIT = 5;
  localparam logic [1:0] NVSEC_UNSECURED_CODE = 2'h2;
  localparam logic [7:0] NVSEC_OPTION_VALID_MASK = 8'hC3;
  localparam logic [7:0] NVSEC_PROTECT_VALID_MASK = 8'hF8;
  localparam int NVSEC_KEY_BYTES = 8;
  localparam logic [7:0] NVSEC_CMD_BLANK_CHECK = 8'h05;
  localparam logic [7:0] NVSEC_CMD_MASS_ERASE = 8'h41;
  localparam logic [2:0] NVSEC_LAST_KEY_INDEX = 3'h7;

  // Load sequence states.
  typedef enum logic [1:0] {
    NVSEC_LOAD_PROT,
    NVSEC_LOAD_OPT,
    NVSEC_LOAD_WAIT,
    NVSEC_RUN
  } nvsec_state_type;

endpackage : nvsec_pkg

// File: hw/nvsec_key_cmp.sv
// Byte-serial comparator of entered key bytes against the stored backdoor key.
`timescale 1ns/1ps
`default_nettype none
module nvsec_key_cmp
  import nvsec_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [63:0] stored_key,
  output logic done,
  output logic match
);

  logic [2:0] index_ff;
  logic ok_ff;
  logic busy_ff;
  logic done_ff;
  logic match_ff;
  logic byte_ok;

  // The entered byte is compared with the stored byte at the same index.
  assign byte_ok = (byte_data == stored_key[{index_ff, 3'h0} +: 8]);

  // Index and running result advance for each accepted byte.
  always_ff @(posedge clk) begin
    if (rst) begin
      index_ff <= 3'h0;
      ok_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else if (start) begin
      index_ff <= 3'h0;
      ok_ff <= 1'b1;
      busy_ff <= 1'b1;
    end else if (busy_ff && byte_valid) begin
      index_ff <= index_ff + 3'h1;
      ok_ff <= ok_ff & byte_ok;
      if (index_ff == NVSEC_LAST_KEY_INDEX) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // One-cycle completion pulse with the overall result.
  always_ff @(posedge clk) begin
    if (rst) begin
      done_ff <= 1'b0;
      match_ff <= 1'b0;
    end else begin
      done_ff <= busy_ff && byte_valid && !start && (index_ff == NVSEC_LAST_KEY_INDEX);
      if (busy_ff && byte_valid && !start && (index_ff == NVSEC_LAST_KEY_INDEX)) begin
        match_ff <= ok_ff & byte_ok;
      end
    end
  end

  assign done = done_ff;
  assign match = match_ff;

endmodule : nvsec_key_cmp
`default_nettype wire

// File: bench/nvsec_top_test.sv
// Self-checking bench for the option load and backdoor key security block.
`timescale 1ns/1ps
`default_nettype none
module nvsec_top_test;
  import nvsec_pkg::*;
  // ****************************************************************************
  // Signals and bookkeeping.
  // ****************************************************************************
  logic clk, rst, reg_wr, reg_rd, exec_secure, bdm_access, nv_rd_valid, rd_q;
  logic flash_cmd_done, flash_blank, nv_rd_req, load_done, secure, key_enabled;
  logic [15:0] reg_addr, nv_rd_addr;
  logic [7:0] reg_wdata, reg_rdata, nv_rd_data, flash_cmd_code, opt, prot;
  logic [63:0] stored_key;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  int err_count, n_compared;

  nvsec_top u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exec_secure(exec_secure),
    .bdm_access(bdm_access), .nv_rd_req(nv_rd_req), .nv_rd_addr(nv_rd_addr),
    .nv_rd_data(nv_rd_data), .nv_rd_valid(nv_rd_valid), .stored_key(stored_key),
    .flash_cmd_done(flash_cmd_done), .flash_cmd_code(flash_cmd_code),
    .flash_blank(flash_blank), .load_done(load_done), .secure(secure),
    .key_enabled(key_enabled));

  // Free-running bus clock at 200 MHz.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************************************************
  // Helpers.
  // ****************************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp_flag

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    exp_q.push_back(e);
  endtask : rd

  task automatic idle;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge clk);
    @(negedge clk);
  endtask : idle

  // Resets the block and serves both stored bytes back to back on the load link.
  task automatic boot(input logic [7:0] p, input logic [7:0] o);
    int i;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    i = 0;
    while (!(nv_rd_req === 1'b1 && nv_rd_addr === NVSEC_STORED_PROTECTION_ADDR) && i < 10) begin
      @(negedge clk);
      i++;
    end
    cmp_flag(nv_rd_addr === NVSEC_STORED_PROTECTION_ADDR, 1'b1);
    @(posedge clk);
    nv_rd_valid <= 1'b1;
    nv_rd_data <= p;
    @(posedge clk);
    nv_rd_data <= o;
    @(negedge clk);
    cmp_flag(nv_rd_addr === NVSEC_STORED_OPTIONS_ADDR, 1'b1);
    @(posedge clk);
    nv_rd_valid <= 1'b0;
    i = 0;
    while (load_done !== 1'b1 && i < 10) begin
      @(negedge clk);
      i++;
    end
    cmp_flag(load_done, 1'b1);
  endtask : boot

  // Opens key access, then enters all eight key bytes, byte 0 first.
  task automatic key(input logic [63:0] k, input logic es, input logic bd);
    @(posedge clk);
    exec_secure <= es;
    bdm_access <= bd;
    wr(NVSEC_FLASH_CONFIG_ADDR, 8'h20);
    for (int i = 0; i < NVSEC_KEY_BYTES; i++) wr(NVSEC_KEY_ENTRY_ADDR, k[8*i +: 8]);
    idle();
    repeat (3) @(negedge clk);
  endtask : key

  task automatic cmd(input logic [7:0] c, input logic b);
    @(posedge clk);
    flash_cmd_done <= 1'b1;
    flash_cmd_code <= c;
    flash_blank <= b;
    @(posedge clk);
    flash_cmd_done <= 1'b0;
    repeat (2) @(negedge clk);
  endtask : cmd

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // Read data stand only in the cycle after the strobe, so they are checked there.
  always @(posedge clk) rd_q <= reg_rd;
  always @(negedge clk) begin
    if (rd_q === 1'b1 && exp_q.size() > 0) cmp_byte(reg_rdata, exp_q.pop_front());
  end

  // Cuts a hung run short after far longer than the tests need.
  initial begin
    #25000;
    err_count++;
    test_done();
  end

  // ****************************************************************************
  // Tests.
  // ****************************************************************************
  initial begin
    {rst, reg_wr, reg_rd, exec_secure, bdm_access, nv_rd_valid, rd_q} = 7'h40;
    {flash_cmd_done, flash_blank, reg_addr, reg_wdata, nv_rd_data, flash_cmd_code} = '0;
    err_count = 0;
    n_compared = 0;
    seed = xs(32'hE220);
    stored_key[31:0] = seed;
    seed = xs(seed);
    stored_key[63:32] = seed;
    seed = xs(seed);
    prot = seed[7:0];
    opt = {1'b1, seed[14:10], 2'h3};
    boot(prot, opt);
    rd(NVSEC_OPTION_WORKING_ADDR, opt & NVSEC_OPTION_VALID_MASK);
    rd(NVSEC_PROTECTION_WORKING_ADDR, prot & NVSEC_PROTECT_VALID_MASK);
    wr(NVSEC_OPTION_WORKING_ADDR, ~opt);
    rd(NVSEC_OPTION_WORKING_ADDR, opt & NVSEC_OPTION_VALID_MASK);
    rd(16'h1822, 8'h00);
    idle();
    cmp_flag(secure, 1'b1);
    cmp_flag(key_enabled, 1'b1);
    $display("load test done");
    key(stored_key, 1'b0, 1'b0);
    cmp_flag(secure, 1'b1);
    key(stored_key, 1'b1, 1'b1);
    cmp_flag(secure, 1'b1);
    key(stored_key ^ {8'h01, 56'h0}, 1'b1, 1'b0);
    cmp_flag(secure, 1'b1);
    rd(NVSEC_STATUS_ADDR, 8'h09);
    idle();
    key(stored_key, 1'b1, 1'b0);
    cmp_flag(secure, 1'b0);
    rd(NVSEC_STATUS_ADDR, 8'h02);
    rd(NVSEC_FLASH_CONFIG_ADDR, 8'h00);
    idle();
    $display("key test done");
    // New stored bytes take effect only across a reset, as after a flash reprogram.
    opt = {1'b0, seed[22:18], 2'h1};
    boot(prot, opt);
    cmp_flag(key_enabled, 1'b0);
    key(stored_key, 1'b1, 1'b0);
    cmp_flag(secure, 1'b1);
    cmd(NVSEC_CMD_MASS_ERASE, 1'b0);
    cmd(8'h20, 1'b0);
    cmd(NVSEC_CMD_BLANK_CHECK, 1'b1);
    cmp_flag(secure, 1'b1);
    cmd(NVSEC_CMD_MASS_ERASE, 1'b0);
    cmd(NVSEC_CMD_BLANK_CHECK, 1'b1);
    cmp_flag(secure, 1'b0);
    rd(NVSEC_STATUS_ADDR, 8'h04);
    idle();
    $display("erase test done");
    opt = {seed[30:25], NVSEC_UNSECURED_CODE};
    boot(prot, opt);
    cmp_flag(secure, 1'b0);
    $display("unsecured code test done");
    test_done();
  end
endmodule : nvsec_top_test
`default_nettype wire
